// File: src/atbwc_defs.vh
/*
 Register offsets, field positions, reset values and timing counts of the
 converter track, burst and window control block.
 Assumes inclusion by bare name from the block's design files.
*/
`ifndef ATBWC_DEFS_VH
`define ATBWC_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Special-function register offsets
`define ATBWC_ADDR_TRACK 8'hBA
`define ATBWC_ADDR_UPPER_HIGH 8'hC4
`define ATBWC_ADDR_UPPER_LOW 8'hC3
`define ATBWC_ADDR_LOWER_LOW 8'hC5
`define ATBWC_ADDR_LOWER_HIGH 8'hC6
`define ATBWC_ADDR_CONTROL 8'hE8
`define ATBWC_ADDR_RESULT_LOW 8'hBD
`define ATBWC_ADDR_RESULT_HIGH 8'hBE

////////////////////////////////////////////////////////////////////////////
// Reset values
`define ATBWC_RST_TRACK 8'hFF
`define ATBWC_RST_UPPER_HIGH 8'hFF
`define ATBWC_RST_UPPER_LOW 8'hFF
`define ATBWC_RST_LOWER_LOW 8'h00
`define ATBWC_RST_LOWER_HIGH 8'h00
`define ATBWC_RST_CONTROL 8'h00

////////////////////////////////////////////////////////////////////////////
// Field positions: track register
`define ATBWC_PWR_HI 7
`define ATBWC_PWR_LO 4
`define ATBWC_TM_HI 3
`define ATBWC_TM_LO 2
`define ATBWC_TK_HI 1
`define ATBWC_TK_LO 0

// Field positions: control register
`define ATBWC_CN_ENABLE 7
`define ATBWC_CN_BURST 6
`define ATBWC_CN_DONE 5
`define ATBWC_CN_BUSY 4
`define ATBWC_CN_WINDOW 3
`define ATBWC_CN_LJUST 2
`define ATBWC_CN_CM_HI 1
`define ATBWC_CN_CM_LO 0

// Tracking mode codes
`define ATBWC_TM_POST 2'h1
`define ATBWC_TM_PRE 2'h2
`define ATBWC_TM_DUAL 2'h3

////////////////////////////////////////////////////////////////////////////
// Timing
`define ATBWC_CLK_PERIOD_NS 10
`define ATBWC_PWR_STEP_NS 200
`define ATBWC_PWR_STEP_CYC \
    ((`ATBWC_PWR_STEP_NS + `ATBWC_CLK_PERIOD_NS - 1) / `ATBWC_CLK_PERIOD_NS)
`define ATBWC_POST_TAIL_CYC 2'h2

`endif

// File: src/atbwc_window.v
/*
 Window comparator: checks each stored result against the two limits.
 Assumes the result, limits and sample strobe come from the same clock.
*/
`timescale 1ns/1ps
module atbwc_window #(
    parameter WIDTH = 16
) (
    input wire clk_sys_in,
    input wire reset_in,
    input wire sample_valid_in,
    input wire [WIDTH-1:0] sample_in,
    input wire [WIDTH-1:0] upper_in,
    input wire [WIDTH-1:0] lower_in,
    output reg match_out
);

////////////////////////////////////////////////////////////////////////////
// Inside or outside by magnitude
function in_window;
    input [WIDTH-1:0] s;
    input [WIDTH-1:0] up;
    input [WIDTH-1:0] lo;
    begin
        if (lo > up)
            in_window = (s > up) && (s < lo);
        else
            in_window = (s > up) || (s < lo);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Raw stored word compared
always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
        match_out <= 1'b0;
    end else begin
        match_out <= sample_valid_in &&
            in_window(sample_in, upper_in, lower_in);
    end
end

endmodule

// File: src/atbwc_top.v
/*
 Track, burst power-up and window control of a 12-bit SAR converter,
 with its special-function registers.
 Assumes a single-cycle register write port on the core clock, a converter
 core that reports busy and a result on this clock, and a SAR clock tick.
*/
`timescale 1ns/1ps
`include "atbwc_defs.vh"
module atbwc_top (
    input wire clk_sys_in,
    input wire reset_in,
    input wire [7:0] sfr_addr_in,
    input wire [7:0] sfr_wdata_in,
    input wire sfr_wr_in,
    output reg [7:0] sfr_rdata_out,
    input wire conv_start_in,
    input wire sar_tick_in,
    input wire core_busy_in,
    input wire result_valid_in,
    input wire [15:0] result_in,
    output wire converter_power_out,
    output wire very_low_power_out,
    output wire burst_osc_select_out,
    output wire [1:0] tracking_mode_select_out,
    output reg convert_go_out,
    output wire window_match_flag_out,
    output wire conversion_done_flag_out,
    output wire left_justify_out
);

localparam S_IDLE = 4'b0001;
localparam S_PWRUP = 4'b0010;
localparam S_TRACK = 4'b0100;
localparam S_CONV = 4'b1000;

reg [7:0] track_burst_config;
reg [7:0] upper_limit_high;
reg [7:0] upper_limit_low;
reg [7:0] lower_limit_low;
reg [7:0] lower_limit_high;
reg [7:0] control;
reg [15:0] result;
reg [3:0] state;
reg [8:0] count;
reg [1:0] tail;
reg busy_prev;
wire window_hit;
wire converter_enable;
wire burst_mode_enable;
wire [3:0] burst_powerup_time;
wire [1:0] post_track_time;
wire sw_start;
wire start_evt;
wire busy_fall;

assign converter_enable = control[`ATBWC_CN_ENABLE];
assign burst_mode_enable = control[`ATBWC_CN_BURST];
assign burst_powerup_time =
    track_burst_config[`ATBWC_PWR_HI:`ATBWC_PWR_LO];
assign post_track_time = track_burst_config[`ATBWC_TK_HI:`ATBWC_TK_LO];
assign tracking_mode_select_out =
    track_burst_config[`ATBWC_TM_HI:`ATBWC_TM_LO];
assign left_justify_out = control[`ATBWC_CN_LJUST];
assign window_match_flag_out = control[`ATBWC_CN_WINDOW];
assign conversion_done_flag_out = control[`ATBWC_CN_DONE];

////////////////////////////////////////////////////////////////////////////
// Power state
// Enable alone without burst
assign converter_power_out = burst_mode_enable ?
    (converter_enable || state != S_IDLE) : converter_enable;
assign very_low_power_out = burst_mode_enable && !converter_enable &&
    state == S_IDLE;
assign burst_osc_select_out = burst_mode_enable;

assign sw_start = sfr_wr_in && sfr_addr_in == `ATBWC_ADDR_CONTROL &&
    sfr_wdata_in[`ATBWC_CN_BUSY] &&
    control[`ATBWC_CN_CM_HI:`ATBWC_CN_CM_LO] == 2'h0;
assign start_evt = sw_start || (conv_start_in &&
    control[`ATBWC_CN_CM_HI:`ATBWC_CN_CM_LO] != 2'h0);
assign busy_fall = busy_prev && !core_busy_in;

function [8:0] pwrup_cycles;
    input [3:0] pwr;
    reg [31:0] full;
    begin
        full = ({28'h0000000, pwr} + 32'h00000001) *
            `ATBWC_PWR_STEP_CYC - 32'h00000001;
        // Longest delay is 320 cycles, fits nine bits
        pwrup_cycles = full[8:0];
    end
endfunction

function needs_post_track;
    input [1:0] tm;
    begin
        needs_post_track = tm == `ATBWC_TM_POST || tm == `ATBWC_TM_DUAL;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Start, power-up and post-track sequencer
always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
        state <= S_IDLE;
        count <= 9'h000;
        tail <= 2'h0;
        convert_go_out <= 1'b0;
    end else begin
        convert_go_out <= 1'b0;
        case (state)
            S_IDLE: begin
                if (start_evt && (converter_enable || burst_mode_enable)) begin
                    if (burst_mode_enable && !converter_enable) begin
                        state <= S_PWRUP;
                        count <= pwrup_cycles(burst_powerup_time);
                    end else if (needs_post_track(
                            tracking_mode_select_out)) begin
                        state <= S_TRACK;
                        count <= {4'h0, 5'h02 << post_track_time};
                        tail <= `ATBWC_POST_TAIL_CYC;
                    end else begin
                        state <= S_CONV;
                        convert_go_out <= 1'b1;
                    end
                end
            end
            S_PWRUP: begin
                if (count != 9'h000) begin
                    count <= count - 9'h001;
                end else if (needs_post_track(tracking_mode_select_out)) begin
                    state <= S_TRACK;
                    count <= {4'h0, 5'h02 << post_track_time};
                    tail <= `ATBWC_POST_TAIL_CYC;
                end else begin
                    state <= S_CONV;
                    convert_go_out <= 1'b1;
                end
            end
            S_TRACK: begin
                if (count != 9'h000) begin
                    if (sar_tick_in)
                        count <= count - 9'h001;
                end else if (tail > 2'h1) begin
                    tail <= tail - 2'h1;
                end else begin
                    // Last tail cycle launches go
                    state <= S_CONV;
                    convert_go_out <= 1'b1;
                end
            end
            S_CONV: begin
                if (busy_fall)
                    state <= S_IDLE;
            end
            default: begin
                state <= S_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Window comparator
// Every stored result compared
atbwc_window #(
    .WIDTH(16)
) u_window (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .sample_valid_in(result_valid_in),
    .sample_in(result_in),
    .upper_in({upper_limit_high, upper_limit_low}),
    .lower_in({lower_limit_high, lower_limit_low}),
    .match_out(window_hit)
);

////////////////////////////////////////////////////////////////////////////
// Registers
always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
        track_burst_config <= `ATBWC_RST_TRACK;
        upper_limit_high <= `ATBWC_RST_UPPER_HIGH;
        upper_limit_low <= `ATBWC_RST_UPPER_LOW;
        lower_limit_low <= `ATBWC_RST_LOWER_LOW;
        lower_limit_high <= `ATBWC_RST_LOWER_HIGH;
        control <= `ATBWC_RST_CONTROL;
        result <= 16'h0000;
        busy_prev <= 1'b0;
    end else begin
        busy_prev <= core_busy_in;
        if (result_valid_in)
            result <= result_in;
        if (sfr_wr_in) begin
            case (sfr_addr_in)
                `ATBWC_ADDR_TRACK: track_burst_config <= sfr_wdata_in;
                `ATBWC_ADDR_UPPER_HIGH: upper_limit_high <= sfr_wdata_in;
                `ATBWC_ADDR_UPPER_LOW: upper_limit_low <= sfr_wdata_in;
                `ATBWC_ADDR_LOWER_LOW: lower_limit_low <= sfr_wdata_in;
                `ATBWC_ADDR_LOWER_HIGH: lower_limit_high <= sfr_wdata_in;
                `ATBWC_ADDR_CONTROL: begin
                    control <= sfr_wdata_in;
                    control[`ATBWC_CN_BUSY] <= 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (busy_fall)
            control[`ATBWC_CN_DONE] <= 1'b1;
        if (window_hit)
            control[`ATBWC_CN_WINDOW] <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// Read data
always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
        sfr_rdata_out <= 8'h00;
    end else begin
        case (sfr_addr_in)
            `ATBWC_ADDR_TRACK: sfr_rdata_out <= track_burst_config;
            `ATBWC_ADDR_UPPER_HIGH: sfr_rdata_out <= upper_limit_high;
            `ATBWC_ADDR_UPPER_LOW: sfr_rdata_out <= upper_limit_low;
            `ATBWC_ADDR_LOWER_LOW: sfr_rdata_out <= lower_limit_low;
            `ATBWC_ADDR_LOWER_HIGH: sfr_rdata_out <= lower_limit_high;
            `ATBWC_ADDR_CONTROL: begin
                sfr_rdata_out <= control;
                sfr_rdata_out[`ATBWC_CN_BUSY] <=
                    core_busy_in || state != S_IDLE;
            end
            `ATBWC_ADDR_RESULT_LOW: sfr_rdata_out <= result[7:0];
            `ATBWC_ADDR_RESULT_HIGH: sfr_rdata_out <= result[15:8];
            default: sfr_rdata_out <= 8'h00;
        endcase
    end
end

endmodule

// File: tb/atbwc_assertions.sv
/*
 Concurrent checks of the track, burst and window control block.
 Assumes binding to atbwc_top, one clock and an active-high reset.
*/
`timescale 1ns/1ps
module atbwc_chk (
    input logic clk_sys_in,
    input logic reset_in,
    input logic [7:0] sfr_addr_in,
    input logic [7:0] sfr_wdata_in,
    input logic sfr_wr_in,
    input logic [7:0] sfr_rdata_out,
    input logic core_busy_in,
    input logic result_valid_in,
    input logic converter_power_out,
    input logic very_low_power_out,
    input logic burst_osc_select_out,
    input logic [1:0] tracking_mode_select_out,
    input logic convert_go_out,
    input logic window_match_flag_out,
    input logic conversion_done_flag_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    wire wr_ctl = sfr_wr_in && sfr_addr_in == 8'hE8;
    wire wr_trk = sfr_wr_in && sfr_addr_in == 8'hBA;
    sequence s_go_pulse;
        convert_go_out ##1 !convert_go_out;
    endsequence
    sequence s_done_next;
        ##1 conversion_done_flag_out;
    endsequence
    a_osc_burst: assert property (
        wr_ctl |=> burst_osc_select_out == $past(sfr_wdata_in[6]))
        else $error("osc select differs from burst bit");
    a_power_enable: assert property (
        wr_ctl && !sfr_wdata_in[6] |=> !very_low_power_out &&
        converter_power_out == $past(sfr_wdata_in[7]))
        else $error("power does not follow enable");
    a_burst_awake: assert property (
        wr_ctl && sfr_wdata_in[7:6] == 2'h3 |=>
        converter_power_out && !very_low_power_out)
        else $error("burst with enable lost power");
    a_sleep_state: assert property (
        very_low_power_out |-> burst_osc_select_out && !converter_power_out)
        else $error("sleep state while not in burst");
    a_mode_field: assert property (
        wr_trk |=> tracking_mode_select_out == $past(sfr_wdata_in[3:2]))
        else $error("tracking mode differs from write");
    a_go_single: assert property (
        convert_go_out |-> s_go_pulse)
        else $error("go pulse longer than one cycle");
    a_win_cause: assert property (
        $rose(window_match_flag_out) && !$past(wr_ctl && sfr_wdata_in[3])
        |-> $past(result_valid_in, 2))
        else $error("window flag rose without a result");
    a_win_sticky: assert property (
        window_match_flag_out && !(wr_ctl && !sfr_wdata_in[3]) |=>
        window_match_flag_out)
        else $error("window flag dropped by itself");
    a_done_fall: assert property (
        $fell(core_busy_in) |-> s_done_next)
        else $error("done flag missing after busy fell");
    a_unmapped_zero: assert property (
        sfr_addr_in == 8'h07 |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind atbwc_top atbwc_chk u_chk (.clk_sys_in, .reset_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_wr_in, .sfr_rdata_out, .core_busy_in,
    .result_valid_in, .converter_power_out, .very_low_power_out,
    .burst_osc_select_out, .tracking_mode_select_out, .convert_go_out,
    .window_match_flag_out, .conversion_done_flag_out);

// File: tb/tb_adc_track_burst_window_ctrl.sv
/*
 Self-checking bench of the track, burst and window control block.
 Assumes the design's register map and start-mode 00 starts.
*/
`timescale 1ns/1ps
module tb_adc_track_burst_window_ctrl;
    reg clk_sys_in = 1'b0;
    reg reset_in = 1'b1;
    reg [7:0] addr = 8'h00, wdata = 8'h00, d;
    reg wr = 1'b0, start = 1'b0, tick = 1'b1, busy = 1'b0, valid = 1'b0;
    reg [15:0] res = 16'h0000, up, lo, rr, n;
    reg [39:0] al = 40'hBAC4C3C5C6, rv = 40'hFFFFFF0000;
    wire [7:0] rdata;
    wire pwr, vlp, osc, go, wflag, dflag, lj;
    wire [1:0] tm;
    integer n_mismatch = 0, checks_done = 0, seed = 19, cyc = 0, i;

    always #5 clk_sys_in = ~clk_sys_in;

    atbwc_top dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr),
        .sfr_rdata_out(rdata), .conv_start_in(start), .sar_tick_in(tick),
        .core_busy_in(busy), .result_valid_in(valid), .result_in(res),
        .converter_power_out(pwr), .very_low_power_out(vlp),
        .burst_osc_select_out(osc), .tracking_mode_select_out(tm),
        .convert_go_out(go), .window_match_flag_out(wflag),
        .conversion_done_flag_out(dflag), .left_justify_out(lj));

    ////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input [15:0] seen, input [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr_reg(input [7:0] a, input [7:0] v);
        @(negedge clk_sys_in);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk_sys_in);
        wr = 1'b0;
    endtask

    task rd(input [7:0] a, input [7:0] e);
        @(negedge clk_sys_in);
        addr = a;
        @(negedge clk_sys_in);
        chk({8'h00, rdata}, {8'h00, e});
    endtask

    function exp_win(input [15:0] r, input [15:0] u, input [15:0] l);
        exp_win = (l > u) ? (r > u && r < l) : (r > u || r < l);
    endfunction

    function [15:0] exp_go(input [7:0] t, input [7:0] c);
        exp_go = 16'h0000;
        if (c[6] && !c[7]) exp_go = exp_go + (t[7:4] + 1) * 20;
        if (t[2]) exp_go = exp_go + (2 << t[1:0]) + 2;
    endfunction

    ////////////////////////////////////////////////////////////////////
    task win(input [15:0] u, input [15:0] l, input [15:0] r, input j);
        wr_reg(8'hC4, u[15:8]);
        wr_reg(8'hC3, u[7:0]);
        wr_reg(8'hC6, l[15:8]);
        wr_reg(8'hC5, l[7:0]);
        wr_reg(8'hE8, {5'h10, j, 2'h0});
        @(negedge clk_sys_in);
        res = r;
        valid = 1'b1;
        @(negedge clk_sys_in);
        valid = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rd(8'hE8, {4'h8, exp_win(r, u, l), j, 2'h0});
        chk({14'h0, wflag, lj}, {14'h0, exp_win(r, u, l), j});
    endtask

    task go_test(input [7:0] t, input [7:0] c);
        wr_reg(8'hBA, t);
        wr_reg(8'hE8, c);
        wr_reg(8'hE8, c | 8'h10);
        n = 16'h0000;
        while (go !== 1'b1 && n < 16'd3000) begin
            @(posedge clk_sys_in);
            #1;
            n = n + 16'h0001;
        end
        chk(n, exp_go(t, c));
        @(negedge clk_sys_in);
        busy = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        busy = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rd(8'hE8, c | 8'h20);
        chk({15'h0, dflag}, 16'h0001);
    endtask

    always @(posedge clk_sys_in) begin
        cyc = cyc + 1;
        if (cyc == 10000) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t run too long", $time);
            tally_and_finish;
        end
    end

    initial begin
        repeat (2) @(negedge clk_sys_in);
        reset_in = 1'b0;
        for (i = 0; i < 5; i = i + 1)
            rd(al[8*i +: 8], rv[8*i +: 8]);
        rd(8'h07, 8'h00);
        chk({14'h0, tm}, 16'h0003);
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(8'hE8, {i[1:0], 6'h00});
            chk({15'h0, pwr}, {15'h0, i[1]});
            chk({15'h0, vlp}, {15'h0, i == 1});
            chk({15'h0, osc}, {15'h0, i[0]});
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(8'hBA, {4'h0, i[1:0], 2'h0});
            chk({14'h0, tm}, {14'h0, i[1:0]});
        end
        for (i = 0; i < 10; i = i + 1) begin
            d = $random(seed);
            wr_reg(al[8*(i%5) +: 8], d);
            rd(al[8*(i%5) +: 8], d);
        end
        win(16'h0100, 16'h0200, 16'h0150, 1'b0);
        win(16'h0100, 16'h0200, 16'h0100, 1'b0);
        win(16'h0100, 16'h0200, 16'h0200, 1'b0);
        win(16'h0200, 16'h0100, 16'h00FF, 1'b0);
        win(16'h0200, 16'h0100, 16'h0150, 1'b0);
        win(16'h0200, 16'h0100, 16'h0201, 1'b0);
        win(16'h0200, 16'h0200, 16'h0200, 1'b0);
        win(16'h1000, 16'h2000, 16'h1800, 1'b1);
        for (i = 0; i < 30; i = i + 1) begin
            up = $random(seed);
            lo = $random(seed);
            rr = $random(seed);
            win(up, lo, rr, i[0]);
        end
        go_test(8'h08, 8'h80);
        go_test(8'h00, 8'h80);
        for (i = 0; i < 4; i = i + 1)
            go_test({6'h01, i[1:0]}, 8'h80);
        go_test(8'h0F, 8'h80);
        go_test(8'h08, 8'h40);
        go_test(8'hF8, 8'h40);
        go_test(8'h35, 8'h40);
        // Reset again in mid-run
        @(negedge clk_sys_in);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        reset_in = 1'b0;
        rd(8'hC4, 8'hFF);
        rd(8'hE8, 8'h00);
        chk({15'h0, dflag}, 16'h0000);
        tally_and_finish;
    end
endmodule
